// ==== logic/ltt_pkg.sv ====
/*
 * Constants shared by the legacy timer trio: register indices, field
 * positions, mode encodings, reset values and prescaler figures.
 * Assumes a single 40 MHz system clock and a classic Wishbone host.
 */
package ltt_pkg;

	// System clock rate and the divide ratios of the internal count clock.
	localparam int unsigned CLK_HZ   = 40_000_000;
	localparam int unsigned DIV_SLOW = 12;
	localparam int unsigned DIV_FAST = 4;
	localparam int unsigned DIV_BAUD = 2;
	localparam logic [3:0]  PRE_LAST = 4'(DIV_SLOW - 1);
	localparam logic [1:0]  FAST_LAST = 2'(DIV_FAST - 1);

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_TMR01_CONTROL = 8'h88;
	localparam logic [7:0] IDX_TMR01_MODE    = 8'h89;
	localparam logic [7:0] IDX_TMR0_CNT_LO   = 8'h8a;
	localparam logic [7:0] IDX_TMR1_CNT_LO   = 8'h8b;
	localparam logic [7:0] IDX_TMR0_CNT_HI   = 8'h8c;
	localparam logic [7:0] IDX_TMR1_CNT_HI   = 8'h8d;
	localparam logic [7:0] IDX_CLK_DIVIDE    = 8'h8e;
	localparam logic [7:0] IDX_TMR2_CONTROL  = 8'hc8;
	localparam logic [7:0] IDX_TMR2_RLD_LO   = 8'hca;
	localparam logic [7:0] IDX_TMR2_RLD_HI   = 8'hcb;
	localparam logic [7:0] IDX_TMR2_CNT_LO   = 8'hcc;
	localparam logic [7:0] IDX_TMR2_CNT_HI   = 8'hcd;

	// Timer 0/1 control register fields.
	localparam int B_TMR1_FLAG = 7;
	localparam int B_TMR1_RUN  = 6;
	localparam int B_TMR0_FLAG = 5;
	localparam int B_TMR0_RUN  = 4;

	// Timer 0/1 mode register: one nibble per timer, timer 1 on top.
	localparam int B_GATE  = 3;
	localparam int B_CSEL  = 2;
	localparam int NIB_HI  = 4;

	// Timer 2 control register fields.
	localparam int B2_FLAG    = 7;
	localparam int B2_EDGE    = 6;
	localparam int B2_RX_SRC  = 5;
	localparam int B2_TX_SRC  = 4;
	localparam int B2_EDGE_EN = 3;
	localparam int B2_RUN     = 2;
	localparam int B2_CSEL    = 1;
	localparam int B2_CPRL    = 0;

	// Clock divide register: one fast-divide bit per timer.
	localparam int B_DIV0 = 3;
	localparam int B_DIV1 = 4;
	localparam int B_DIV2 = 5;

	// Reset values and byte limits.
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [7:0]  BYTE_ONES = 8'hff;
	localparam logic [15:0] WORD_ONES = 16'hffff;
	localparam logic [4:0]  PRE5_ONES = 5'h1f;

	// Timer 0/1 operating modes, encoded as in the mode field.
	typedef enum logic [1:0] {
		LTT_MODE_13BIT   = 2'b00,
		LTT_MODE_16BIT   = 2'b01,
		LTT_MODE_RELOAD8 = 2'b10,
		LTT_MODE_SPLIT   = 2'b11
	} ltt_mode_e;

endpackage

// ==== logic/ltt_timers.sv ====
/*
 * Legacy timer trio: timers 0 and 1 with four modes, and timer 2 with
 * auto-reload, capture and baud generation, behind a Wishbone slave.
 * Assumes count pins are asynchronous and the ISR entry strobes come
 * from the interrupt controller on the same clock.
 */
// Local design decision: register access over Wishbone.
// Notes on behaviour
// - Timers 0/1 tick every 12 clocks, or 4 with the divide bit.
// - Timer 2 ticks every 12 or 4, or 2 in baud.
// - Counter mode counts pin falling edges, sampled.
// - ISR entry clears timer 0/1 overflow flags.
// - Run bit low halts and holds count.
// - Gate bit makes pin gate the counting.
// - Counter select picks pin or divided clock.
// - Mode 00: 5-bit prescaler feeding 8-bit counter.
// - Mode 01: cascaded 16-bit counter.
// - Mode 10: low byte reloads from high.
// - Mode 11 splits timer 0 in two.
// - Timer 2 flag software cleared, blocked in baud.
// - Edge flag set on enabled pin fall.
// - Source bits pick timer 2 or 1 baud.
// - Edge enable gates capture or reload edges.
// - Timer 2 select counts pin or clock.
// - Reload on overflow and enabled edge.
// - Baud mode forces reload; pin select still wins.
// - Auto-reload overflow sets flag, reloads 16 bits.
// - Capture edge copies count into reload pair.
// - Timer 2 run bit low stops counting; an enabled edge still reloads it.
// - One pin feeds timer 2 count and capture.
// - Divide bit picks clock by 4 or 12.
`timescale 1ns/100ps

module ltt_timers
	import ltt_pkg::*;
(
	// Clock and reset.
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// External count, gate and capture pins.
	input  wire logic        tmr0_count_pin_i,
	input  wire logic        tmr1_count_pin_i,
	input  wire logic        tmr2_count_pin_i,
	// Interrupt service entry strobes.
	input  wire logic        tmr0_isr_entry_i,
	input  wire logic        tmr1_isr_entry_i,
	// Flags and serial baud ticks.
	output logic             tmr0_ovf_flag_o,
	output logic             tmr1_ovf_flag_o,
	output logic             tmr2_ovf_flag_o,
	output logic             tmr2_edge_flag_o,
	output logic             rx_baud_tick_o,
	output logic             tx_baud_tick_o
);

	// One step of a timer 0/1 count: {overflow, high byte, low byte}.
	function automatic logic [16:0] cnt_step(input ltt_mode_e m,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			LTT_MODE_13BIT: begin
				if (lo[4:0] == PRE5_ONES) begin
					r = {hi == BYTE_ONES, hi + 8'h01, lo[7:5], 5'h00};
				end else begin
					r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
				end
			end
			LTT_MODE_16BIT: r = {{hi, lo} == WORD_ONES, {hi, lo} + 16'h0001};
			LTT_MODE_RELOAD8: begin
				if (lo == BYTE_ONES) r = {1'b1, hi, hi};
				else r = {1'b0, hi, lo + 8'h01};
			end
			default: r = {1'b0, hi, lo}; // Timer 1 holds while it is itself in split mode.
		endcase
		return r;
	endfunction

	// Count source: pin edge or the divided system clock.
	function automatic logic src_tick(input logic csel, input logic fall,
		input logic fast, input logic t4, input logic t12);
		return csel ? fall : (fast ? t4 : t12);
	endfunction

	logic [3:0]  pre_cnt_r;
	logic        tick12, tick4, tick2;
	logic [2:0]  pin_meta_r, pin_sync_r, pin_prev_r;
	logic [2:0]  pin_fall;
	logic        wb_ack_r;
	logic [7:0]  reg_idx, wdat, rd_mux;
	logic        wr_go;
	logic        wr_ctl01, wr_mode01, wr_lo0, wr_lo1, wr_hi0, wr_hi1;
	logic        wr_div, wr_ctl2, wr_rld_lo, wr_rld_hi, wr_cnt2_lo, wr_cnt2_hi;
	logic        tmr0_run_r, tmr1_run_r;
	logic [3:0]  ext_int_bits_r;
	logic [7:0]  tmr01_mode_r;
	logic [2:0]  div_sel_r;
	logic [7:0]  tmr0_lo_r, tmr0_hi_r, tmr1_lo_r, tmr1_hi_r;
	logic        tmr0_ovf_flag_r, tmr1_ovf_flag_r;
	ltt_mode_e   tmr0_mode, tmr1_mode;
	logic        tmr0_en, tmr1_en, tmr0_hi_en;
	logic [16:0] tmr0_step, tmr1_step;
	logic        tmr0_ovf, tmr1_ovf, tmr0_hi_ovf, tmr1_flag_set;
	logic [5:0]  tmr2_ctl_r;
	logic        tmr2_ovf_flag_r, tmr2_edge_flag_r;
	logic [15:0] tmr2_cnt_r, tmr2_rld_r;
	logic        baud_mode, tmr2_en, tmr2_ovf, tmr2_edge_evt;
	logic        rx_baud_r, tx_baud_r;

	// Shared prescaler; the fast and baud ticks are evenly spaced inside it.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || pre_cnt_r == PRE_LAST) pre_cnt_r <= 4'h0;
		else pre_cnt_r <= pre_cnt_r + 4'h1;
	end
	assign tick12 = (pre_cnt_r == PRE_LAST);
	assign tick4  = (pre_cnt_r[1:0] == FAST_LAST);
	assign tick2  = pre_cnt_r[0];

	// Pins pass two flops; a third stage gives the previous sample.
	// Timer 2 counting and capture both read the same synchronised pin.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
			pin_prev_r <= 3'h0;
		end else begin
			pin_meta_r <= {tmr2_count_pin_i, tmr1_count_pin_i, tmr0_count_pin_i};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end
	assign pin_fall = pin_prev_r & ~pin_sync_r;

	// Wishbone: ack one cycle after the request; writes land on the ack edge.
	assign reg_idx = wb_adr_i[9:2];
	assign wdat    = wb_dat_i[7:0];
	assign wr_go   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r && wb_sel_i[0];
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wb_ack_r <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
			if (wb_cyc_i && wb_stb_i && !wb_ack_r && !wb_we_i) wb_dat_o <= {24'h0, rd_mux};
		end
	end
	assign wb_ack_o = wb_ack_r;

	// Write decodes for each register.
	assign wr_ctl01   = wr_go && (reg_idx == IDX_TMR01_CONTROL);
	assign wr_mode01  = wr_go && (reg_idx == IDX_TMR01_MODE);
	assign wr_lo0     = wr_go && (reg_idx == IDX_TMR0_CNT_LO);
	assign wr_lo1     = wr_go && (reg_idx == IDX_TMR1_CNT_LO);
	assign wr_hi0     = wr_go && (reg_idx == IDX_TMR0_CNT_HI);
	assign wr_hi1     = wr_go && (reg_idx == IDX_TMR1_CNT_HI);
	assign wr_div     = wr_go && (reg_idx == IDX_CLK_DIVIDE);
	assign wr_ctl2    = wr_go && (reg_idx == IDX_TMR2_CONTROL);
	assign wr_rld_lo  = wr_go && (reg_idx == IDX_TMR2_RLD_LO);
	assign wr_rld_hi  = wr_go && (reg_idx == IDX_TMR2_RLD_HI);
	assign wr_cnt2_lo = wr_go && (reg_idx == IDX_TMR2_CNT_LO);
	assign wr_cnt2_hi = wr_go && (reg_idx == IDX_TMR2_CNT_HI);

	// Read mux; unmapped indices read as zero and still get an ack.
	always_comb begin
		case (reg_idx)
			IDX_TMR01_CONTROL: rd_mux = {tmr1_ovf_flag_r, tmr1_run_r, tmr0_ovf_flag_r,
				tmr0_run_r, ext_int_bits_r};
			IDX_TMR01_MODE:    rd_mux = tmr01_mode_r;
			IDX_TMR0_CNT_LO:   rd_mux = tmr0_lo_r;
			IDX_TMR1_CNT_LO:   rd_mux = tmr1_lo_r;
			IDX_TMR0_CNT_HI:   rd_mux = tmr0_hi_r;
			IDX_TMR1_CNT_HI:   rd_mux = tmr1_hi_r;
			IDX_CLK_DIVIDE:    rd_mux = {2'h0, div_sel_r, 3'h0};
			IDX_TMR2_CONTROL:  rd_mux = {tmr2_ovf_flag_r, tmr2_edge_flag_r, tmr2_ctl_r};
			IDX_TMR2_RLD_LO:   rd_mux = tmr2_rld_r[7:0];
			IDX_TMR2_RLD_HI:   rd_mux = tmr2_rld_r[15:8];
			IDX_TMR2_CNT_LO:   rd_mux = tmr2_cnt_r[7:0];
			IDX_TMR2_CNT_HI:   rd_mux = tmr2_cnt_r[15:8];
			default:           rd_mux = RST_BYTE;
		endcase
	end

	// Plain control registers. Interrupt pin bits are stored only.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr0_run_r     <= 1'b0;
			tmr1_run_r     <= 1'b0;
			ext_int_bits_r <= 4'h0;
			tmr01_mode_r   <= RST_BYTE;
			div_sel_r      <= 3'h0;
			tmr2_ctl_r     <= 6'h0;
		end else begin
			if (wr_ctl01) begin
				tmr0_run_r     <= wdat[B_TMR0_RUN];
				tmr1_run_r     <= wdat[B_TMR1_RUN];
				ext_int_bits_r <= wdat[3:0];
			end
			if (wr_mode01) tmr01_mode_r <= wdat;
			if (wr_div) div_sel_r <= {wdat[B_DIV2], wdat[B_DIV1], wdat[B_DIV0]};
			if (wr_ctl2) tmr2_ctl_r <= wdat[5:0];
		end
	end

	// Timer 0/1 enables: run bit, optional pin gate, then the count source.
	assign tmr0_mode = ltt_mode_e'(tmr01_mode_r[1:0]);
	assign tmr1_mode = ltt_mode_e'(tmr01_mode_r[NIB_HI+1:NIB_HI]);
	assign tmr0_en = tmr0_run_r && (!tmr01_mode_r[B_GATE] || pin_sync_r[0]) &&
		src_tick(tmr01_mode_r[B_CSEL], pin_fall[0], div_sel_r[0], tick4, tick12);
	assign tmr1_en = tmr1_run_r && (!tmr01_mode_r[NIB_HI+B_GATE] || pin_sync_r[1]) &&
		src_tick(tmr01_mode_r[NIB_HI+B_CSEL], pin_fall[1], div_sel_r[1], tick4, tick12);
	// Split high half of timer 0 runs off timer 1's run bit and the clock.
	assign tmr0_hi_en = tmr1_run_r && (div_sel_r[0] ? tick4 : tick12);
	assign tmr0_step = cnt_step(tmr0_mode, tmr0_hi_r, tmr0_lo_r);
	assign tmr1_step = cnt_step(tmr1_mode, tmr1_hi_r, tmr1_lo_r);
	assign tmr0_ovf = tmr0_en && ((tmr0_mode == LTT_MODE_SPLIT) ?
		(tmr0_lo_r == BYTE_ONES) : tmr0_step[16]);
	assign tmr0_hi_ovf = (tmr0_mode == LTT_MODE_SPLIT) && tmr0_hi_en &&
		(tmr0_hi_r == BYTE_ONES);
	assign tmr1_ovf = tmr1_en && tmr1_step[16];
	// While timer 0 is split, its high half owns timer 1's flag.
	assign tmr1_flag_set = (tmr0_mode == LTT_MODE_SPLIT) ? tmr0_hi_ovf : tmr1_ovf;

	// Timer 0 count; a software write in the same cycle wins over a tick.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr0_lo_r <= RST_BYTE;
			tmr0_hi_r <= RST_BYTE;
		end else begin
			if (tmr0_mode == LTT_MODE_SPLIT) begin
				if (tmr0_en) tmr0_lo_r <= tmr0_lo_r + 8'h01;
				if (tmr0_hi_en) tmr0_hi_r <= tmr0_hi_r + 8'h01;
			end else if (tmr0_en) begin
				{tmr0_hi_r, tmr0_lo_r} <= tmr0_step[15:0];
			end
			if (wr_lo0) tmr0_lo_r <= wdat;
			if (wr_hi0) tmr0_hi_r <= wdat;
		end
	end

	// Timer 1 count; it holds in its own split mode.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr1_lo_r <= RST_BYTE;
			tmr1_hi_r <= RST_BYTE;
		end else begin
			if (tmr1_en) {tmr1_hi_r, tmr1_lo_r} <= tmr1_step[15:0];
			if (wr_lo1) tmr1_lo_r <= wdat;
			if (wr_hi1) tmr1_hi_r <= wdat;
		end
	end

	// Timer 0/1 flags: overflow set beats ISR entry, which beats software.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr0_ovf_flag_r <= 1'b0;
			tmr1_ovf_flag_r <= 1'b0;
		end else begin
			if (tmr0_ovf) tmr0_ovf_flag_r <= 1'b1;
			else if (tmr0_isr_entry_i) tmr0_ovf_flag_r <= 1'b0;
			else if (wr_ctl01) tmr0_ovf_flag_r <= wdat[B_TMR0_FLAG];
			if (tmr1_flag_set) tmr1_ovf_flag_r <= 1'b1;
			else if (tmr1_isr_entry_i) tmr1_ovf_flag_r <= 1'b0;
			else if (wr_ctl01) tmr1_ovf_flag_r <= wdat[B_TMR1_FLAG];
		end
	end

	// Timer 2 decode. Baud mode runs at half the clock unless the pin counts.
	assign baud_mode = tmr2_ctl_r[B2_RX_SRC] || tmr2_ctl_r[B2_TX_SRC];
	assign tmr2_en = tmr2_ctl_r[B2_RUN] && (tmr2_ctl_r[B2_CSEL] ? pin_fall[2] :
		(baud_mode ? tick2 : (div_sel_r[2] ? tick4 : tick12)));
	assign tmr2_ovf = tmr2_en && (tmr2_cnt_r == WORD_ONES);
	assign tmr2_edge_evt = pin_fall[2] && tmr2_ctl_r[B2_EDGE_EN];

	// Timer 2 count: reload on overflow unless capturing; edge reload too.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr2_cnt_r <= 16'h0;
		end else begin
			if (tmr2_ovf) begin
				if (baud_mode || !tmr2_ctl_r[B2_CPRL]) tmr2_cnt_r <= tmr2_rld_r;
				else tmr2_cnt_r <= 16'h0;
			end else if (tmr2_edge_evt && !baud_mode && !tmr2_ctl_r[B2_CPRL]) begin
				tmr2_cnt_r <= tmr2_rld_r;
			end else if (tmr2_en) begin
				tmr2_cnt_r <= tmr2_cnt_r + 16'h0001;
			end
			if (wr_cnt2_lo) tmr2_cnt_r[7:0] <= wdat;
			if (wr_cnt2_hi) tmr2_cnt_r[15:8] <= wdat;
		end
	end

	// Reload/capture pair. Baud mode never captures, since it must reload.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr2_rld_r <= 16'h0;
		end else begin
			if (tmr2_edge_evt && !baud_mode && tmr2_ctl_r[B2_CPRL]) tmr2_rld_r <= tmr2_cnt_r;
			if (wr_rld_lo) tmr2_rld_r[7:0] <= wdat;
			if (wr_rld_hi) tmr2_rld_r[15:8] <= wdat;
		end
	end

	// Timer 2 flags: hardware set wins over a software clear.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr2_ovf_flag_r  <= 1'b0;
			tmr2_edge_flag_r <= 1'b0;
		end else begin
			if (tmr2_ovf && !baud_mode) tmr2_ovf_flag_r <= 1'b1;
			else if (wr_ctl2) tmr2_ovf_flag_r <= wdat[B2_FLAG];
			if (tmr2_edge_evt) tmr2_edge_flag_r <= 1'b1;
			else if (wr_ctl2) tmr2_edge_flag_r <= wdat[B2_EDGE];
		end
	end

	// Serial baud ticks, one registered pulse per chosen overflow.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rx_baud_r <= 1'b0;
			tx_baud_r <= 1'b0;
		end else begin
			rx_baud_r <= tmr2_ctl_r[B2_RX_SRC] ? tmr2_ovf : tmr1_ovf;
			tx_baud_r <= tmr2_ctl_r[B2_TX_SRC] ? tmr2_ovf : tmr1_ovf;
		end
	end

	assign tmr0_ovf_flag_o  = tmr0_ovf_flag_r;
	assign tmr1_ovf_flag_o  = tmr1_ovf_flag_r;
	assign tmr2_ovf_flag_o  = tmr2_ovf_flag_r;
	assign tmr2_edge_flag_o = tmr2_edge_flag_r;
	assign rx_baud_tick_o   = rx_baud_r;
	assign tx_baud_tick_o   = tx_baud_r;

	// Checks on the timing and the flag and reload behaviour.
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_capture_edge;
		tmr2_edge_evt && tmr2_ctl_r[B2_CPRL] && !baud_mode && !wr_rld_lo && !wr_rld_hi;
	endsequence

	a_slow_tick_period: assert property (tick12 |-> ##12 tick12 ##1 !tick12)
		else $error("Slow tick spacing is not twelve clocks.");
	a_baud_tick_period: assert property (tick2 |-> ##1 !tick2 ##1 tick2)
		else $error("Baud tick spacing is not two clocks.");
	a_fall_one_cycle: assert property (pin_fall[0] |=> !pin_fall[0])
		else $error("Edge strobe lasted more than one cycle.");
	a_halt_holds_count: assert property (!tmr0_run_r && tmr0_mode != LTT_MODE_SPLIT
		&& !wr_lo0 && !wr_hi0 |=> $stable({tmr0_hi_r, tmr0_lo_r}))
		else $error("Stopped timer 0 changed its count.");
	a_gate_blocks_count: assert property (tmr01_mode_r[B_GATE] && !pin_sync_r[0]
		&& tmr0_mode != LTT_MODE_SPLIT && !wr_lo0 && !wr_hi0 |=> $stable(tmr0_lo_r))
		else $error("Gated timer 0 counted with the pin low.");
	a_mode2_reload: assert property (tmr0_mode == LTT_MODE_RELOAD8 && tmr0_en
		&& tmr0_lo_r == BYTE_ONES && !wr_lo0 |=> tmr0_lo_r == $past(tmr0_hi_r)
		&& tmr0_ovf_flag_r)
		else $error("Low byte did not reload from high byte.");
	a_isr_clears_flag: assert property (tmr0_isr_entry_i && !tmr0_ovf |=> !tmr0_ovf_flag_r)
		else $error("ISR entry did not clear timer 0 flag.");
	a_baud_no_flag: assert property (baud_mode && !tmr2_ovf_flag_r && !wr_ctl2
		|=> !tmr2_ovf_flag_r)
		else $error("Timer 2 flag set in baud mode.");
	a_capture_copies: assert property (s_capture_edge |=> tmr2_rld_r == $past(tmr2_cnt_r)
		&& tmr2_edge_flag_r)
		else $error("Capture edge did not copy the count.");
	a_baud_forces_reload: assert property (tmr2_ovf && baud_mode && !wr_cnt2_lo
		&& !wr_cnt2_hi |=> tmr2_cnt_r == $past(tmr2_rld_r)
		&& (rx_baud_tick_o || !$past(tmr2_ctl_r[B2_RX_SRC])))
		else $error("Baud overflow did not reload timer 2.");

endmodule

// ==== verification/ltt_pin_model.sv ====
/*
 * Far-side model of the timer trio's pins: the three count pins.
 * Assumes its tasks are called just after a rising clock edge.
 */
`timescale 1ns/100ps

module ltt_pin_model (
	// Clock of the device whose pins are driven.
	input  wire logic       sys_clk_i,
	// Count pins; pin 2 also serves timer 2 capture.
	output logic      [2:0] pin_o
);
	// Pins idle high, so a later drop is a clean falling edge.
	initial pin_o = 3'b111;

	// Drops one pin n times; len picks a prompt or a slow pulse.
	task automatic fall(input int which, input int n, input int len);
		for (int i = 0; i < n; i++) begin
			pin_o[which] <= 1'b0;
			repeat (len) @(posedge sys_clk_i);
			pin_o[which] <= 1'b1;
			repeat (len) @(posedge sys_clk_i);
		end
	endtask

	// Parks one pin at a level, used as a gate.
	task automatic level(input int which, input logic v);
		pin_o[which] <= v;
		@(posedge sys_clk_i);
	endtask
endmodule

// ==== verification/test_legacy_timers_zero_one_two.sv ====
/*
 * Self-checking bench for the timer trio: registers, rates, modes,
 * gating, flags and timer 2. Assumes one 40 MHz clock.
 */
`timescale 1ns/100ps

module test_legacy_timers_zero_one_two
	import ltt_pkg::*;
;
	logic        sys_clk_i, rst_i, cyc, stb, we, ack, f0, f1, f2, e2, rxt, txt;
	logic [1:0]  isr, fq;
	logic [2:0]  pin;
	logic [3:0]  sel;
	logic [9:0]  adr;
	logic [31:0] wdat, dat, rdat;
	int          fails = 0, samples_checked = 0, txn = 0, rxn = 0, r0 = 0, r1 = 0;

	ltt_timers i_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat),
		.wb_ack_o(ack), .tmr0_count_pin_i(pin[0]), .tmr1_count_pin_i(pin[1]),
		.tmr2_count_pin_i(pin[2]), .tmr0_isr_entry_i(isr[0]), .tmr1_isr_entry_i(isr[1]),
		.tmr0_ovf_flag_o(f0), .tmr1_ovf_flag_o(f1), .tmr2_ovf_flag_o(f2),
		.tmr2_edge_flag_o(e2), .rx_baud_tick_o(rxt), .tx_baud_tick_o(txt)
	);
	ltt_pin_model i_pins (.sys_clk_i(sys_clk_i), .pin_o(pin));

	// A 25 ns clock.
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	// Counts baud ticks and flag rises, since a stop write may clear a flag.
	always @(posedge sys_clk_i) begin
		fq <= {f1, f0};
		if (txt === 1'b1) txn <= txn + 1;
		if (rxt === 1'b1) rxn <= rxn + 1;
		if (f0 === 1'b1 && fq[0] === 1'b0) r0 <= r0 + 1;
		if (f1 === 1'b1 && fq[1] === 1'b0) r1 <= r1 + 1;
	end

	// Compares one value and counts it.
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// One classic Wishbone cycle; the gap cycle keeps requests apart.
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		{cyc, stb, we, sel} <= {2'b11, w, 4'h1};
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do @(posedge sys_clk_i); while (ack !== 1'b1);
		rdat = dat;
		{cyc, stb, we, sel} <= 7'h0;
		@(posedge sys_clk_i);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rd(input string n, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h0);
		check(n, {8'h0, rdat[7:0]}, {8'h0, e});
	endtask

	// Word access; the high byte is read first as there is no snapshot.
	task automatic wr2(input logic [7:0] ilo, input logic [15:0] v);
		wr(ilo, v[7:0]);
		wr(ilo + 8'h1, v[15:8]);
	endtask

	task automatic rd2(input string n, input logic [7:0] ilo, input logic [15:0] e);
		logic [7:0] h;
		bus(1'b0, ilo + 8'h1, 8'h0);
		h = rdat[7:0];
		bus(1'b0, ilo, 8'h0);
		check(n, {h, rdat[7:0]}, e);
	endtask

	// Write effects land exactly 12*k edges apart, so any prescaler phase gives k slow ticks.
	task automatic win(input logic [7:0] idx, input logic [7:0] on, input logic [7:0] off,
		input int k);
		wr(idx, on);
		repeat (12 * k - 3) @(posedge sys_clk_i);
		wr(idx, off);
	endtask

	task automatic pulse(input int t);
		isr[t] <= 1'b1;
		@(posedge sys_clk_i);
		isr <= 2'b00;
		@(posedge sys_clk_i);
	endtask

	task automatic t_regs();
		rd("mode reset", IDX_TMR01_MODE, 8'h00);
		rd("tmr2 ctl reset", IDX_TMR2_CONTROL, 8'h00);
		wr(IDX_TMR1_CNT_HI, 8'ha5);
		rd("tmr1 hi", IDX_TMR1_CNT_HI, 8'ha5);
		wr(8'h90, 8'h3c);
		rd("unmapped", 8'h90, 8'h00);
	endtask

	// Timer 0 at /12 and timer 1 at /4, then a long pause while halted.
	task automatic t_rate();
		wr(IDX_TMR01_MODE, 8'h11);
		wr(IDX_CLK_DIVIDE, 8'h10);
		win(IDX_TMR01_CONTROL, 8'h50, 8'h00, 2);
		repeat (30) @(posedge sys_clk_i);
		rd("tmr0 slow", IDX_TMR0_CNT_LO, 8'h02);
		rd("tmr1 fast", IDX_TMR1_CNT_LO, 8'h06);
		wr(IDX_CLK_DIVIDE, 8'h00);
	endtask

	task automatic tmr0_modes(input logic [7:0] m, input logic [7:0] hi, input logic [7:0] lo,
		input logic [7:0] ehi, input logic [7:0] elo, input logic ef);
		int b0;
		b0 = r0;
		wr(IDX_TMR01_MODE, m);
		wr(IDX_TMR0_CNT_HI, hi);
		wr(IDX_TMR0_CNT_LO, lo);
		win(IDX_TMR01_CONTROL, 8'h10, 8'h00, 1);
		rd("tmr0 hi", IDX_TMR0_CNT_HI, ehi);
		rd("tmr0 lo", IDX_TMR0_CNT_LO, elo);
		check("tmr0 flag", 16'(r0 - b0), {15'h0, ef});
	endtask

	// Split mode: the high half runs on timer 1's run bit and flag.
	task automatic t_split();
		int b1;
		b1 = r1;
		wr(IDX_TMR01_MODE, 8'h03);
		wr(IDX_TMR0_CNT_HI, 8'hff);
		win(IDX_TMR01_CONTROL, 8'h40, 8'h00, 1);
		rd("split hi", IDX_TMR0_CNT_HI, 8'h00);
		rd("split lo", IDX_TMR0_CNT_LO, 8'h40);
		check("split flag", 16'(r1 - b1), 16'h1);
		wr(IDX_TMR01_CONTROL, 8'h80);
		check("tmr1 flag set", {15'h0, f1}, 16'h1);
		pulse(1);
		check("tmr1 flag isr", {15'h0, f1}, 16'h0);
		wr(IDX_TMR01_CONTROL, 8'h20);
		check("tmr0 flag set", {15'h0, f0}, 16'h1);
		pulse(0);
		check("tmr0 flag isr", {15'h0, f0}, 16'h0);
	endtask

	// Gate closed, gate open, then counting pin edges.
	task automatic t_pins();
		wr(IDX_TMR01_MODE, 8'h09);
		wr(IDX_TMR0_CNT_LO, 8'h00);
		i_pins.level(0, 1'b0);
		win(IDX_TMR01_CONTROL, 8'h10, 8'h00, 2);
		rd("gate low", IDX_TMR0_CNT_LO, 8'h00);
		i_pins.level(0, 1'b1);
		win(IDX_TMR01_CONTROL, 8'h10, 8'h00, 2);
		rd("gate high", IDX_TMR0_CNT_LO, 8'h02);
		wr(IDX_TMR01_MODE, 8'h05);
		wr(IDX_TMR01_CONTROL, 8'h10);
		i_pins.fall(0, 3, 2);
		wr(IDX_TMR01_CONTROL, 8'h00);
		rd("pin count", IDX_TMR0_CNT_LO, 8'h05);
	endtask

	task automatic t_tmr2();
		int n0;
		int n1;
		wr2(IDX_TMR2_RLD_LO, 16'h1234);
		wr2(IDX_TMR2_CNT_LO, 16'hfffe);
		wr(IDX_TMR2_CONTROL, 8'h06);
		i_pins.fall(2, 3, 2);
		rd2("tmr2 reload", IDX_TMR2_CNT_LO, 16'h1235);
		check("tmr2 flag", {15'h0, f2}, 16'h1);
		wr(IDX_TMR2_CONTROL, 8'h00);
		check("tmr2 flag sw", {15'h0, f2}, 16'h0);
		// Timer 2 on the fast divided clock gives three ticks in twelve edges.
		wr(IDX_CLK_DIVIDE, 8'h20);
		wr2(IDX_TMR2_CNT_LO, 16'h0000);
		win(IDX_TMR2_CONTROL, 8'h04, 8'h00, 1);
		rd2("tmr2 fast", IDX_TMR2_CNT_LO, 16'h0003);
		wr(IDX_CLK_DIVIDE, 8'h00);
		wr2(IDX_TMR2_RLD_LO, 16'habcd);
		// Baud service on transmit, then on receive, at the /2 rate.
		for (int i = 0; i < 2; i++) begin
			n0 = txn;
			n1 = rxn;
			wr2(IDX_TMR2_CNT_LO, 16'hffff);
			win(IDX_TMR2_CONTROL, (i == 0) ? 8'h14 : 8'h24, 8'h00, 1);
			rd2("tmr2 baud", IDX_TMR2_CNT_LO, 16'habd2);
			check("tx ticks", 16'(txn - n0), 16'(1 - i));
			check("rx ticks", 16'(rxn - n1), 16'(i));
			check("baud flag", {15'h0, f2}, 16'h0);
		end
		wr2(IDX_TMR2_CNT_LO, 16'h5678);
		wr(IDX_TMR2_CONTROL, 8'h09);
		i_pins.fall(2, 1, 5);
		rd2("capture", IDX_TMR2_RLD_LO, 16'h5678);
		check("edge flag", {15'h0, e2}, 16'h1);
		wr(IDX_TMR2_CONTROL, 8'h01);
		wr2(IDX_TMR2_CNT_LO, 16'h1111);
		i_pins.fall(2, 1, 2);
		rd2("no capture", IDX_TMR2_RLD_LO, 16'h5678);
		check("edge off", {15'h0, e2}, 16'h0);
		wr(IDX_TMR2_CONTROL, 8'h08);
		i_pins.fall(2, 1, 2);
		rd2("edge reload", IDX_TMR2_CNT_LO, 16'h5678);
	endtask

	task automatic summarize();
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		{cyc, stb, we, isr, sel, adr, wdat} = '0;
		rst_i = 1'b1;
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_regs();
		t_rate();
		tmr0_modes(8'h00, 8'hff, 8'hff, 8'h00, 8'he0, 1'b1);
		tmr0_modes(8'h01, 8'h12, 8'hff, 8'h13, 8'h00, 1'b0);
		tmr0_modes(8'h02, 8'h40, 8'hff, 8'h40, 8'h40, 1'b1);
		t_split();
		t_pins();
		t_tmr2();
		summarize();
	end

	// The whole run needs under 2000 cycles; a hang ends here.
	initial begin
		repeat (6000) @(posedge sys_clk_i);
		fails++;
		summarize();
	end
endmodule
